// ==== src/spc_pkg.sv ====
// Purpose: shared constants and types for the standby power controller
// Assumes: 250 MHz clock from the always-on domain
// Notes: times are kept in their own units, cycle counts derive from them
package spc_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TOGGLE_MIN_MS = 50;
  localparam int unsigned READY_DELAY_MS = 300;
  localparam int unsigned AUTO_WAKE_S = 120;
  localparam int unsigned MS_CYCLES = CLK_MHZ * 1000;
  localparam int unsigned TOGGLE_MIN_CYC = TOGGLE_MIN_MS * MS_CYCLES;
  localparam int unsigned READY_DELAY_CYC = READY_DELAY_MS * MS_CYCLES;
  localparam longint unsigned AUTO_WAKE_CYC =
    64'(AUTO_WAKE_S) * 64'(MS_CYCLES) * 64'd1000;
  localparam int CNT_W = 36;

  typedef enum logic [2:0] {
    SPC_OFF = 3'b000,
    SPC_BOOT = 3'b001,
    SPC_ACTIVE = 3'b011,
    SPC_WIND = 3'b010,
    SPC_UNMOUNT = 3'b110,
    SPC_STANDBY = 3'b111,
    SPC_PAUSE = 3'b101
  } spc_state_t;

  // handshake with the software that stops tasks and unmounts the card
  typedef struct packed {
    logic tasks_done;
    logic card_unmounted;
  } spc_sw_ack_t;

  typedef struct packed {
    logic stop_tasks;
    logic unmount_card;
    logic reboot;
  } spc_sw_req_t;
endpackage : spc_pkg

// ==== src/spc_top.sv ====
// Purpose: standby and power-state sequencer on the always-on supply
// Assumes: sw_ack from logic on clk, power toggle pin asynchronous
// Notes: long counts are parameters so simulation can shorten them
//
// Overview of operation
// - a 50 ms low on the toggle input toggles the state; shorter doesn't.
// - a software power-mode standby command also requests standby.
// - tasks stop and the card unmounts before the supply request drops.
// - the operating indicator is high when running, low in standby or reset.
// - the indicator rises about 300 ms after power-up, reset or wake.
// - in standby a 50 ms low wakes, raises the request and reboots.
// - the toggle input has a pull-up and is debounced internally.
// - without a switch, standby only pauses and auto-wakes after 2 minutes.
// - there are seven states: off, boot, active, wind-down and unmount in order, then standby or pause, which are alternatives.
`timescale 1ns/1ps
module spc_top
  import spc_pkg::*;
#(
  parameter int unsigned TOGGLE_CYC = TOGGLE_MIN_CYC,
  parameter int unsigned READY_CYC = READY_DELAY_CYC,
  parameter longint unsigned WAKE_CYC = AUTO_WAKE_CYC
) (
  input wire logic clk, // always-on clock
  input wire logic sys_rst, // async reset, active high
  input wire logic power_toggle_input, // push-button pin, low active
  input wire logic power_mode_command, // one-cycle standby command
  input wire logic switch_fitted, // external switch present
  input wire spc_pkg::spc_sw_ack_t sw_ack, // software done levels
  output logic toggle_pull_up, // pull-up enable on the button pin
  output logic supply_switch_request, // high keeps main supply on
  output logic module_ready, // operating indicator
  output spc_pkg::spc_sw_req_t sw_req // requests to software
);
  import spc_pkg::*;

  logic [2:0] sync_reg;
  logic level_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic toggle_reg;
  logic [CNT_W-1:0] tmr_reg;
  spc_state_t state_reg;

  // three-stage synchroniser; stage 0 feeds stage 1 only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_reg <= 3'h7;
    end else begin
      sync_reg <= {sync_reg[1:0], power_toggle_input};
    end
  end

  // accepted level moves only when stages 1 and 2 agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_reg <= 1'b1;
    end else if (sync_reg[1] == sync_reg[2]) begin
      level_reg <= sync_reg[2];
    end
  end

  // count continuous low time; one pulse when it reaches the minimum
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_reg <= '0;
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= 1'b0;
      if (level_reg) begin
        low_cnt_reg <= '0;
      end else if (low_cnt_reg < CNT_W'(TOGGLE_CYC)) begin
        low_cnt_reg <= low_cnt_reg + 1'b1;
        toggle_reg <= (low_cnt_reg == CNT_W'(TOGGLE_CYC - 1));
      end
    end
  end

  // state sequence; a held button fires once, the counter saturates
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SPC_OFF;
      tmr_reg <= '0;
    end else begin
      unique case (state_reg)
        SPC_OFF: begin
          state_reg <= SPC_BOOT;
          tmr_reg <= '0;
        end
        SPC_BOOT: begin
          if (tmr_reg >= CNT_W'(READY_CYC - 1)) begin
            state_reg <= SPC_ACTIVE;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        SPC_ACTIVE: begin
          if (toggle_reg || power_mode_command) begin
            state_reg <= SPC_WIND;
          end
        end
        SPC_WIND: begin
          if (sw_ack.tasks_done) begin
            state_reg <= SPC_UNMOUNT;
          end
        end
        SPC_UNMOUNT: begin
          tmr_reg <= '0;
          if (sw_ack.card_unmounted) begin
            // no switch: no low-power state, just a timed pause
            state_reg <= switch_fitted ? SPC_STANDBY : SPC_PAUSE;
          end
        end
        SPC_STANDBY: begin
          tmr_reg <= '0;
          if (toggle_reg) begin
            state_reg <= SPC_BOOT;
          end
        end
        SPC_PAUSE: begin
          if (toggle_reg || tmr_reg >= CNT_W'(WAKE_CYC - 1)) begin
            state_reg <= SPC_BOOT;
            tmr_reg <= '0;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= SPC_OFF;
        end
      endcase
    end
  end

  // outputs registered; supply stays up until the card is safe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_switch_request <= 1'b1;
      module_ready <= 1'b0;
      sw_req <= '0;
      toggle_pull_up <= 1'b1;
    end else begin
      toggle_pull_up <= 1'b1;
      supply_switch_request <= (state_reg != SPC_STANDBY);
      module_ready <= (state_reg == SPC_ACTIVE);
      sw_req.stop_tasks <= (state_reg == SPC_WIND);
      sw_req.unmount_card <= (state_reg == SPC_UNMOUNT);
      sw_req.reboot <= (state_reg == SPC_BOOT);
    end
  end

  property p_short_no_toggle;
    @(posedge clk) disable iff (sys_rst)
      level_reg |=> !toggle_reg;
  endproperty
  a_short_no_toggle: assert property (p_short_no_toggle)
    else $error("toggle fired while input high");

  property p_cmd_standby;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == SPC_ACTIVE && power_mode_command) |=>
        state_reg == SPC_WIND;
  endproperty
  a_cmd_standby: assert property (p_cmd_standby)
    else $error("standby command ignored");

  sequence s_wound_down;
    state_reg == SPC_UNMOUNT && sw_ack.card_unmounted && switch_fitted;
  endsequence
  property p_drop_after_unmount;
    @(posedge clk) disable iff (sys_rst)
      s_wound_down |=> ##1 !supply_switch_request;
  endproperty
  a_drop_after_unmount: assert property (p_drop_after_unmount)
    else $error("supply not dropped after unmount");

  property p_supply_kept;
    @(posedge clk) disable iff (sys_rst)
      $fell(supply_switch_request) |-> $past(state_reg, 2) == SPC_UNMOUNT;
  endproperty
  a_supply_kept: assert property (p_supply_kept)
    else $error("supply dropped outside standby");

  property p_ready_level;
    @(posedge clk) disable iff (sys_rst)
      module_ready |-> $past(state_reg) == SPC_ACTIVE;
  endproperty
  a_ready_level: assert property (p_ready_level)
    else $error("ready high while not running");

  property p_ready_after_boot;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == SPC_BOOT && tmr_reg == CNT_W'(READY_CYC - 1)) |=>
        ##1 module_ready;
  endproperty
  a_ready_after_boot: assert property (p_ready_after_boot)
    else $error("ready did not rise after boot delay");

  property p_wake;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == SPC_STANDBY && toggle_reg) |=> ##1 supply_switch_request;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not raise supply request");

  property p_pause_keeps_supply;
    @(posedge clk) disable iff (sys_rst)
      state_reg == SPC_PAUSE |=> supply_switch_request;
  endproperty
  a_pause_keeps_supply: assert property (p_pause_keeps_supply)
    else $error("supply dropped without switch");

  property p_standby_order;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == SPC_STANDBY && $changed(state_reg)) |->
        $past(state_reg) == SPC_UNMOUNT;
  endproperty
  a_standby_order: assert property (p_standby_order)
    else $error("standby entered without orderly shutdown");

  property p_single_pulse;
    @(posedge clk) disable iff (sys_rst)
      toggle_reg |=> !toggle_reg;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("toggle pulse longer than one cycle");
endmodule : spc_top

// ==== tb/spc_partner.sv ====
// Purpose: far-side model, main supply switch and push-button
// Assumes: button idles released, pin lifted by the device pull-up
// Notes: supply follows the request at once, a real switch is slower
`timescale 1ns/1ps
module spc_partner (
  input wire logic clk, // always-on clock
  input wire logic supply_switch_request, // switch control
  input wire logic toggle_pull_up, // device pull-up enable
  output logic power_toggle_input, // button pin
  output logic main_supply // switched supply, high = on
);
  logic pressed = 1'b0;
  assign main_supply = supply_switch_request;
  // released pin floats to whatever the pull-up gives
  assign power_toggle_input = pressed ? 1'b0 : toggle_pull_up;
  task automatic press(input int cyc);
    @(posedge clk) pressed <= 1'b1;
    repeat (cyc) @(posedge clk);
    pressed <= 1'b0;
  endtask : press
endmodule : spc_partner

// ==== tb/test_standby_power_controller.sv ====
// Purpose: self-checking bench for the standby power controller
// Assumes: shortened counts, partner drives the button pin
// Notes: mst models the state and predicts ready and supply
`timescale 1ns/1ps
module test_standby_power_controller;
  import spc_pkg::*;
  localparam int TC = 20, RC = 30, WC = 100;
  logic clk = 1'b0, sys_rst = 1'b1, cmd = 1'b0, fitted = 1'b1;
  logic pin, pu, req, rdy, main_sup;
  spc_sw_ack_t ack = '0;
  spc_sw_req_t swr;
  int bad_count = 0, n_checks = 0, mst = 0, n = 0;
  logic [16:0] rnd = 17'h17ddd;
  spc_top #(.TOGGLE_CYC(TC), .READY_CYC(RC), .WAKE_CYC(WC)) uut (
    .clk(clk), .sys_rst(sys_rst), .power_toggle_input(pin),
    .power_mode_command(cmd), .switch_fitted(fitted), .sw_ack(ack),
    .toggle_pull_up(pu), .supply_switch_request(req),
    .module_ready(rdy), .sw_req(swr));
  spc_partner u_sw (.clk(clk), .supply_switch_request(req),
    .toggle_pull_up(pu), .power_toggle_input(pin),
    .main_supply(main_sup));
  initial forever #2 clk = ~clk;
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic s, input logic e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %b expected %b", $time, s, e);
    end
  endtask : chk
  task automatic model_cmp;
    chk(rdy, mst == 1);
    chk(req, mst != 2);
    chk(main_sup, mst != 2);
    chk(pu, 1'b1);
  endtask : model_cmp
  function automatic logic sig(input int k);
    case (k)
      0: return rdy;
      1: return swr.stop_tasks;
      2: return swr.unmount_card;
      3: return ~req;
      default: return req;
    endcase
  endfunction : sig
  // sampled at the falling edge, away from the driving edge
  task automatic wait_sig(input int k, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sig(k) !== 1'b1 && n <= lim);
    if (sig(k) !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t wait %0d timed out", $time, k);
      tally_and_finish();
    end
  endtask : wait_sig
  task automatic shutdown(input logic by_cmd);
    if (by_cmd) begin
      @(posedge clk) cmd <= 1'b1;
      @(posedge clk) cmd <= 1'b0;
    end else begin
      fork
        u_sw.press(TC + 10);
      join_none
    end
    wait_sig(1, TC + 20);
    if (!by_cmd) chk(n >= TC, 1'b1);
    rnd = lfsr(rnd);
    repeat (rnd[3:0]) @(negedge clk);
    chk(req, 1'b1);
    @(posedge clk) ack.tasks_done <= 1'b1;
    wait_sig(2, 10);
    chk(req, 1'b1);
    @(posedge clk) ack.card_unmounted <= 1'b1;
    mst = fitted ? 2 : 3;
    if (fitted) wait_sig(3, 8);
    else repeat (10) @(negedge clk);
    model_cmp();
    @(posedge clk) ack <= '0;
  endtask : shutdown
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) model_cmp();
    @(posedge clk) sys_rst <= 1'b0;
    wait_sig(0, RC + 10);
    chk(n >= RC, 1'b1);
    mst = 1;
    model_cmp();
    rnd = lfsr(rnd);
    u_sw.press(1 + int'(rnd % 17'(TC - 6)));
    repeat (TC + 10) @(negedge clk);
    chk(swr.stop_tasks, 1'b0);
    model_cmp();
    shutdown(1'b1);
    fork
      u_sw.press(TC + 10);
    join_none
    wait_sig(4, TC + 20);
    chk(n >= TC, 1'b1);
    chk(swr.reboot, 1'b1);
    mst = 0;
    model_cmp();
    wait_sig(0, RC + 10);
    chk(n >= RC - 2, 1'b1);
    mst = 1;
    model_cmp();
    @(posedge clk) fitted <= 1'b0;
    shutdown(1'b0);
    wait_sig(0, WC + RC + 30);
    chk(n >= WC + RC - 20, 1'b1);
    mst = 1;
    model_cmp();
    // reset from the running state: indicator low, then the boot delay again
    @(posedge clk) sys_rst <= 1'b1;
    repeat (4) @(negedge clk);
    mst = 0;
    model_cmp();
    @(posedge clk) sys_rst <= 1'b0;
    wait_sig(0, RC + 10);
    chk(n >= RC, 1'b1);
    mst = 1;
    model_cmp();
    tally_and_finish();
  end
endmodule : test_standby_power_controller
